// ==== port_ctl_defs.vh ====
// Register offsets, field positions, reset values and timing counts for the
// converter result, pin port and power-save register group.
// Assumes an 8-bit register address and 8-bit data from the serial host bus.
`ifndef PORT_CTL_DEFS_VH
`define PORT_CTL_DEFS_VH

`define OFS_SENSE_CURRENT_RESULT   8'hc3
`define OFS_THERMAL_VOLTAGE_RESULT 8'hc4
`define OFS_PIN_DIRECTION          8'hc8
`define OFS_PIN_OUTPUT_LEVEL       8'hc9
`define OFS_PIN_INPUT_LEVEL        8'hca
`define OFS_ROLE_SETTLED_WAKE      8'hcb
`define OFS_CONVERTER_CONTROL      8'hc0

`define RST_RESULT                 8'h00
`define RST_PIN_DIRECTION          3'h0
`define RST_PIN_OUTPUT_LEVEL       3'h0
`define RST_THERMAL_DRIVE          2'h0
`define RST_SCAN_SELECT            3'h1
`define RST_CONTROL_TOP            1'h1
`define RST_ROLE_SETTLED           1'h0

`define POS_ROLE_SETTLED           5
`define POS_THERMAL_DRIVE_LO       5
`define POS_SCAN_SELECT_LO         0

// Scan interval base, 4 ms, counted at 200 MHz (5 ns period)
`define SCAN_BASE_MS               4
`define CLOCK_PERIOD_NS            5
`define SCAN_BASE_CYCLES           ((`SCAN_BASE_MS * 1000000) / `CLOCK_PERIOD_NS)

`endif

// ==== port_ctl_regs.v ====
// Host-visible register group: converter results, three-pin port, power-save
// control, plus the converter control register that steers scan and drive.
// Assumes a single-cycle register port decoded from the serial host bus, and
// an analog converter that presents each finished code with a one-cycle strobe.
// Pad levels arrive unsynchronised; converter strobes come on the device clock.
// Scan timing assumes the device clock is the only time base of the block.
`default_nettype none
`include "port_ctl_defs.vh"

// Overview of operation
// RULE1: Three direction bits, zero means input
// RULE2: Output pins drive the stored level
// RULE3: Input level bits report synchronised pin levels
// RULE4: Sense current code, read-only, resets zero
// RULE5: Thermal voltage code, read-only, resets zero
// RULE6: Thermal code spans 0.4V to 2.4V
// RULE7: Source selected current out of thermal pin
// RULE8: Settled bit set wakes internal circuits
// RULE9: Settled bit cleared keeps power-saving state
// RULE10: Settled bit reads back device state
// RULE11: Drive field picks four pin currents
// RULE12: Conversions repeat at selected scan interval
// RULE13: Reserved bits zero, results update atomically
module port_ctl_regs #(
    parameter         PIN_COUNT   = 3,
    parameter integer SCAN_CYCLES = `SCAN_BASE_CYCLES
) (
    input  wire                 i_clock,
    input  wire                 i_nrst,
    input  wire                 i_reg_write,
    input  wire                 i_reg_read,
    input  wire [7:0]           i_reg_addr,
    input  wire [7:0]           i_reg_wdata,
    output reg  [7:0]           o_reg_rdata,
    input  wire [PIN_COUNT-1:0] i_pin_in,
    output reg  [PIN_COUNT-1:0] o_pin_out,
    output reg  [PIN_COUNT-1:0] o_pin_oe,
    input  wire                 i_sense_current_done,
    input  wire [7:0]           i_sense_current_code,
    input  wire                 i_thermal_done,
    input  wire [7:0]           i_thermal_code,
    output reg                  o_convert_start,
    output reg                  o_thermal_source_en,
    output reg  [1:0]           o_thermal_drive_current_select,
    output reg                  o_circuits_active
);

    // Converter results
    reg [7:0]           sense_current_q;
    reg [7:0]           thermal_voltage_q;

    // Host-written pin state and the input synchroniser stages
    reg [PIN_COUNT-1:0] pin_direction_q;
    reg [PIN_COUNT-1:0] pin_out_level_q;
    reg [PIN_COUNT-1:0] pin_sync1_q;
    reg [PIN_COUNT-1:0] pin_in_level_q;

    // Power-save and converter control state
    reg                 role_settled_q;
    reg [1:0]           thermal_drive_q;
    reg [2:0]           scan_select_q;
    reg                 control_top_q;

    // Scan timer and read path
    reg [31:0]          scan_count_q;
    reg                 thermal_busy_q;
    reg [7:0]           rdata_d;

    // Decoded write strobes and scan timer terms
    wire                wr_pin_direction;
    wire                wr_pin_out_level;
    wire                wr_role_settled;
    wire                wr_control;
    wire [31:0]         scan_limit;
    wire                scan_wrap;

    // Scan period in cycles: base interval doubled per select step, 101 tops out
    function [31:0] scan_period;
        input [2:0] sel;
        reg   [2:0] s;
        begin
            s = (sel > 3'h5) ? 3'h5 : sel;
            scan_period = SCAN_CYCLES << s;
        end
    endfunction

    // Offset match shared by every write decode below
    function addr_hit;
        input [7:0] addr;
        input [7:0] offset;
        begin
            addr_hit = (addr == offset);
        end
    endfunction

    // A write strobe only touches the register whose offset it carries
    assign wr_pin_direction = i_reg_write & addr_hit(i_reg_addr, `OFS_PIN_DIRECTION);
    assign wr_pin_out_level = i_reg_write & addr_hit(i_reg_addr, `OFS_PIN_OUTPUT_LEVEL);
    assign wr_role_settled  = i_reg_write & addr_hit(i_reg_addr, `OFS_ROLE_SETTLED_WAKE);
    assign wr_control       = i_reg_write & addr_hit(i_reg_addr, `OFS_CONVERTER_CONTROL);

    // Interval length for the present select and the last cycle of it
    assign scan_limit = scan_period(scan_select_q);
    assign scan_wrap  = (scan_count_q + 32'h1) >= scan_limit;

    // Direction bits; zero keeps a pad an input, so reset leaves all pins undriven
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            pin_direction_q <= `RST_PIN_DIRECTION; // RULE1
        end else if (wr_pin_direction) begin
            pin_direction_q <= i_reg_wdata[PIN_COUNT-1:0]; // RULE1
        end
    end

    // Stored output levels; kept for input pins too, so the host may
    // preload a level before it turns the pin around
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            pin_out_level_q <= `RST_PIN_OUTPUT_LEVEL;
        end else if (wr_pin_out_level) begin
            pin_out_level_q <= i_reg_wdata[PIN_COUNT-1:0]; // RULE2
        end
    end

    // Settled bit: only its own bit is stored, the rest of the byte is dropped
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            role_settled_q <= `RST_ROLE_SETTLED; // RULE9
        end else if (wr_role_settled) begin
            role_settled_q <= i_reg_wdata[`POS_ROLE_SETTLED]; // RULE8 RULE9 RULE13
        end
    end

    // Converter control: top bit, drive select and scan select are stored;
    // the two bits between drive and scan select are not kept and read zero
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            control_top_q   <= `RST_CONTROL_TOP;
            thermal_drive_q <= `RST_THERMAL_DRIVE; // RULE11
            scan_select_q   <= `RST_SCAN_SELECT; // RULE12
        end else if (wr_control) begin
            control_top_q   <= i_reg_wdata[7];
            thermal_drive_q <= i_reg_wdata[`POS_THERMAL_DRIVE_LO +: 2]; // RULE11
            scan_select_q   <= i_reg_wdata[`POS_SCAN_SELECT_LO +: 3]; // RULE12
        end
    end

    // Pin levels pass two flip-flops before anything reads them;
    // the first stage may go metastable, so only the second one is read
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            pin_sync1_q    <= {PIN_COUNT{1'b0}};
            pin_in_level_q <= {PIN_COUNT{1'b0}};
        end else begin
            pin_sync1_q    <= i_pin_in;
            pin_in_level_q <= pin_sync1_q; // RULE3
        end
    end

    // Pad output level, registered so the pad never sees decode glitches
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_pin_out <= {PIN_COUNT{1'b0}};
        end else begin
            o_pin_out <= pin_out_level_q; // RULE2
        end
    end

    // Pad output enable, high while the pin is driven
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_pin_oe <= {PIN_COUNT{1'b0}};
        end else begin
            o_pin_oe <= pin_direction_q; // RULE1 RULE2
        end
    end

    // Current result loads a whole code on its strobe, never a partial byte
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            sense_current_q <= `RST_RESULT; // RULE4
        end else if (i_sense_current_done) begin
            sense_current_q <= i_sense_current_code; // RULE13
        end
    end

    // Thermal result: the byte is only captured here, the host applies
    // the span and step scaling to turn it into a voltage
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            thermal_voltage_q <= `RST_RESULT; // RULE5
        end else if (i_thermal_done) begin
            thermal_voltage_q <= i_thermal_code; // RULE6 RULE13
        end
    end

    // Scan counter: runs freely and wraps at the end of each interval; a
    // shorter select written mid-interval ends the current one at its new length, or at once if the count is already past it
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            scan_count_q <= 32'h0;
        end else if (scan_wrap) begin
            scan_count_q <= 32'h0;
        end else begin
            scan_count_q <= scan_count_q + 32'h1;
        end
    end

    // One-cycle start strobe in the cycle after the wrap cycle
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_convert_start <= 1'b0;
        end else begin
            o_convert_start <= scan_wrap; // RULE12
        end
    end

    // Thermal measurement window: opens with each start, closes on the
    // thermal strobe; a scan wrap in the same cycle as a strobe wins, so the
    // fresh measurement still gets its drive current
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            thermal_busy_q <= 1'b0;
        end else if (scan_wrap) begin
            thermal_busy_q <= 1'b1; // RULE7
        end else if (i_thermal_done) begin
            thermal_busy_q <= 1'b0;
        end
    end

    // Pin current enable follows the measurement window one cycle later
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_thermal_source_en <= 1'b0;
        end else begin
            o_thermal_source_en <= thermal_busy_q; // RULE7
        end
    end

    // Current select for the analog side; it may change while a measurement
    // runs, so the host should settle it between scans
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_thermal_drive_current_select <= `RST_THERMAL_DRIVE;
        end else begin
            o_thermal_drive_current_select <= thermal_drive_q; // RULE7 RULE11
        end
    end

    // Circuit activation tracks the settled bit; clearing it drops back to
    // the power-saving state on the next cycle
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_circuits_active <= 1'b0;
        end else begin
            o_circuits_active <= role_settled_q; // RULE8 RULE9
        end
    end

    // Pin bytes: pin bits at the bottom, reserved bits above read zero
    function [7:0] pin_byte;
        input [PIN_COUNT-1:0] bits;
        begin
            pin_byte = {{(8-PIN_COUNT){1'b0}}, bits};
        end
    endfunction

    // Read multiplexer; reserved bits and unmapped offsets read zero, and a
    // read that meets a write in one cycle returns the value before the write
    always @* begin
        rdata_d = 8'h00; // RULE13
        case (i_reg_addr)
            `OFS_SENSE_CURRENT_RESULT:   rdata_d = sense_current_q; // RULE4
            `OFS_THERMAL_VOLTAGE_RESULT: rdata_d = thermal_voltage_q; // RULE5
            `OFS_PIN_DIRECTION:          rdata_d = pin_byte(pin_direction_q); // RULE1
            `OFS_PIN_OUTPUT_LEVEL:       rdata_d = pin_byte(pin_out_level_q); // RULE2
            `OFS_PIN_INPUT_LEVEL:        rdata_d = pin_byte(pin_in_level_q); // RULE3
            `OFS_ROLE_SETTLED_WAKE:      rdata_d[`POS_ROLE_SETTLED] = role_settled_q; // RULE10
            `OFS_CONVERTER_CONTROL:
                rdata_d = {control_top_q, thermal_drive_q, 2'h0, scan_select_q};
            default:                     rdata_d = 8'h00;
        endcase
    end

    // Read data registered on the read strobe and held until the next read,
    // so the host may pick it up late
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst)
            o_reg_rdata <= 8'h00;
        else if (i_reg_read)
            o_reg_rdata <= rdata_d;
    end

endmodule
`default_nettype wire

// ==== port_ctl_regs_props.sv ====
// Checker for the result, pin and power-save register group
// Bound to port_ctl_regs; one clock, async active-low reset
`default_nettype none
module port_ctl_regs_props #(parameter integer SCAN_CYCLES = 8) (
    input wire logic       i_clock, i_nrst, i_reg_write, i_reg_read, i_thermal_done,
    input wire logic       o_convert_start, o_thermal_source_en, o_circuits_active,
    input wire logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata,
    input wire logic [2:0] o_pin_oe, o_pin_out,
    input wire logic [1:0] o_thermal_drive_current_select
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dc @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    // Decoded register strobes
    wire wr_dir = i_reg_write && i_reg_addr == 8'hc8;
    wire wr_out = i_reg_write && i_reg_addr == 8'hc9;
    wire wr_wake = i_reg_write && i_reg_addr == 8'hcb;
    wire wr_ctl = i_reg_write && i_reg_addr == 8'hc0;
    wire rd_wake = i_reg_read && !i_reg_write && i_reg_addr == 8'hcb;
    a_oe_dir: assert property (wr_dir |=> ##1 o_pin_oe == $past(i_reg_wdata[2:0], 2))
        else $error("pin enable mismatch");
    a_out_cause: assert property ($changed(o_pin_out) |-> $past(wr_out || wr_dir, 2))
        else $error("pin level changed unasked");
    a_rdata_hold: assert property (!i_reg_read |=> $stable(o_reg_rdata))
        else $error("read data moved");
    a_wake_lag: assert property (wr_wake |=> ##1 o_circuits_active == $past(i_reg_wdata[5], 2))
        else $error("wake state mismatch");
    a_wake_read: assert property (rd_wake |=> o_reg_rdata == {2'h0, o_circuits_active, 5'h0})
        else $error("wake readback mismatch");
    a_drive_sel: assert property (wr_ctl |=> ##1
        o_thermal_drive_current_select == $past(i_reg_wdata[6:5], 2))
        else $error("drive select mismatch");
    a_src_end: assert property ((i_thermal_done ##1 !o_convert_start) |=> !o_thermal_source_en)
        else $error("thermal source stays on");
    a_src_start: assert property (o_convert_start |=> o_thermal_source_en)
        else $error("thermal source not on");
    a_scan_gap: assert property (o_convert_start |=> !o_convert_start [*7])
        else $error("scan starts too close");
    cover property (wr_wake && i_reg_wdata[5]);
    cover property (i_thermal_done);
    cover property (o_convert_start);
    cover property (wr_wake && !i_reg_wdata[5]);
endmodule
`default_nettype wire

// ==== conv_model.sv ====
// Converter model: answers each scan start with both result codes
// Acts off the falling edge; codes are scrambled outside the done pulse
`default_nettype none
module conv_model (
    input  wire logic       i_clock, i_start,
    input  wire logic [2:0] i_lag,
    input  wire logic [7:0] i_code,
    output wire logic       o_done,
    output wire logic [7:0] o_cur_code, o_tm_code
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt = 4'h0;
    // Conversion takes i_lag cycles after each start
    always @(negedge i_clock) begin
        if (i_start) cnt <= {1'b0, i_lag} + 4'h1;
        else if (cnt != 4'h0) cnt <= cnt - 4'h1;
    end
    // Codes are only valid with done
    assign o_done = (cnt == 4'h1);
    assign o_cur_code = o_done ? i_code : ~i_code;
    assign o_tm_code = o_done ? {i_code[3:0], i_code[7:4]} : ~i_code;
endmodule
`default_nettype wire

// ==== adc_result_gpio_power_save_regs_tb_top.sv ====
// Testbench for the result, pin and power-save register group
// Drives the register port and pads on the falling edge; conv_model feeds codes
`default_nettype none
module adc_result_gpio_power_save_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clock = 1'b0, i_nrst = 1'b0, i_reg_write = 1'b0, i_reg_read = 1'b0, done;
    logic o_convert_start, o_thermal_source_en, o_circuits_active;
    logic [7:0] i_reg_addr = 8'h0, i_reg_wdata = 8'h0, o_reg_rdata, code = 8'h0, rv, d;
    logic [7:0] cur_code, tm_code;
    logic [7:0] tbl [8] = '{8'hc0, 8'hc3, 8'hc4, 8'hc8, 8'hc9, 8'hca, 8'hcb, 8'hd0};
    logic [2:0] o_pin_out, o_pin_oe, ext = 3'h0, lag = 3'h2;
    logic [1:0] o_thermal_drive_current_select;
    logic [15:0] seed = 16'h8cb7;
    int fails = 0, checked = 0, n, c;
    wire [2:0] i_pin_in = (o_pin_oe & o_pin_out) | (~o_pin_oe & ext);
    port_ctl_regs #(.SCAN_CYCLES(8)) i_port_ctl_regs (.*, .i_sense_current_done(done),
        .i_sense_current_code(cur_code), .i_thermal_done(done), .i_thermal_code(tm_code));
    conv_model i_conv_model (.i_clock(i_clock), .i_start(o_convert_start), .i_lag(lag),
        .i_code(code), .o_done(done), .o_cur_code(cur_code), .o_tm_code(tm_code));
    initial forever #2.5 i_clock = ~i_clock;
    function logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function logic [7:0] exp_wr(input logic [7:0] a, input logic [7:0] v);
        case (a)
            8'hc0: return v & 8'he7;
            8'hc8, 8'hc9: return v & 8'h07;
            8'hcb: return v & 8'h20;
            default: return 8'h00;
        endcase
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge i_clock) {i_reg_write, i_reg_addr, i_reg_wdata} = {1'b1, a, v};
        @(negedge i_clock) i_reg_write = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge i_clock) {i_reg_read, i_reg_addr} = {1'b1, a};
        @(negedge i_clock) i_reg_read = 1'b0;
        @(negedge i_clock) rv = o_reg_rdata;
    endtask
    task automatic next_start;
        c = 0;
        do begin @(negedge i_clock); c++; end while (!o_convert_start && c < 600);
    endtask
    task automatic final_report;
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Watchdog
    initial begin #100000; fails++; final_report; end
    // Main sequence
    initial begin
        repeat (2) @(negedge i_clock);
        i_nrst = 1'b1;
        for (n = 0; n < 8; n++) begin
            rd(tbl[n]); chk(rv, tbl[n] == 8'hc0 ? 8'h81 : 8'h00);
        end
        for (n = 1; n < 8; n += 2) begin
            wr(tbl[n], 8'hff); rd(tbl[n]); chk(rv, exp_wr(tbl[n], 8'hff));
        end
        repeat (12) begin
            seed = lfsr(seed);
            ext = seed[10:8];
            wr(8'hc8, seed[7:0]); wr(8'hc9, {seed[2:0], seed[15:11]}); rd(8'hc8);
            chk(rv, {5'h0, seed[2:0]});
            chk({5'h0, o_pin_oe}, {5'h0, seed[2:0]});
            chk({5'h0, o_pin_out & o_pin_oe}, {5'h0, seed[13:11] & seed[2:0]});
            rd(8'hca); chk(rv & {5'h0, ~seed[2:0]}, {5'h0, ext & ~seed[2:0]});
            rd(8'hc9); chk(rv, {5'h0, seed[13:11]});
        end
        for (n = 0; n < 2; n++) begin
            d = n ? 8'hdf : 8'hff;
            wr(8'hcb, d); rd(8'hcb); chk(rv, exp_wr(8'hcb, d));
            chk({7'h0, o_circuits_active}, {7'h0, d[5]});
        end
        for (n = 0; n < 6; n++) begin
            seed = lfsr(seed);
            code = seed[7:0];
            lag = {1'b0, seed[9:8]} + 3'h2;
            d = {1'b1, seed[11:10], 2'h0, n[2:0]};
            wr(8'hc0, d); rd(8'hc0); chk(rv, exp_wr(8'hc0, d));
            chk({6'h0, o_thermal_drive_current_select}, {6'h0, d[6:5]});
            next_start; next_start; next_start;
            chk(8'(c - 8), 8'((8 << n) - 8));
            repeat (6) @(negedge i_clock);
            rd(8'hc3); chk(rv, code);
            rd(8'hc4); chk(rv, {code[3:0], code[7:4]});
        end
        @(negedge i_clock) i_nrst = 1'b0;
        @(negedge i_clock) i_nrst = 1'b1;
        rd(8'hc0); chk(rv, 8'h81);
        chk({5'h0, o_pin_oe}, 8'h00);
        final_report;
    end
endmodule
bind port_ctl_regs port_ctl_regs_props #(.SCAN_CYCLES(SCAN_CYCLES)) u_props (.*);
`default_nettype wire
